/* File: design/sppr_pkg.sv */
package sppr_pkg;

  localparam int unsigned SPPR_ADDR_W = 15;

  // byte register offsets
  localparam logic [14:0] SPPR_PHASE_LOW_ADDR = 15'h0021;
  localparam logic [14:0] SPPR_PHASE_MID_ADDR = 15'h0022;
  localparam logic [14:0] SPPR_PHASE_HIGH_ADDR = 15'h0023;
  localparam logic [14:0] SPPR_RETIME_DIV_ADDR = 15'h0024;
  localparam logic [14:0] SPPR_WAIT_LOW_ADDR = 15'h0025;
  localparam logic [14:0] SPPR_WAIT_HIGH_ADDR = 15'h0026;
  localparam logic [14:0] SPPR_RSVD_A_ADDR = 15'h0027;
  localparam logic [14:0] SPPR_MOD_DITHER_ADDR = 15'h0028;
  localparam logic [14:0] SPPR_AMPLITUDE_ADDR = 15'h0029;
  localparam logic [14:0] SPPR_AUX_PD_ADDR = 15'h002a;
  localparam logic [14:0] SPPR_MAIN_PD_ADDR = 15'h002b;
  localparam logic [14:0] SPPR_LOCK_CFG_ADDR = 15'h002c;

  // reset values
  localparam logic [7:0] SPPR_ZERO_RESET = 8'h00;
  localparam logic [7:0] SPPR_AUX_PD_RESET = 8'h04;
  localparam logic [7:0] SPPR_MAIN_PD_RESET = 8'h83;

  // retime / divider register fields
  localparam int unsigned SPPR_RETIME_EDGE_BIT = 7;
  localparam int unsigned SPPR_POLARITY_LSB = 5;
  localparam int unsigned SPPR_DIV_SOURCE_BIT = 4;
  localparam int unsigned SPPR_FB_DIV_LSB = 2;
  localparam int unsigned SPPR_SHARED_DIV_LSB = 0;

  // modulator register fields
  localparam int unsigned SPPR_RESYNC_SRC_BIT = 7;
  localparam int unsigned SPPR_LSB_PLUS_ONE_ENABLE_BIT = 6;
  localparam int unsigned SPPR_AUX_MOD_BIT = 5;
  localparam int unsigned SPPR_DITHER_POS_LSB = 2;
  localparam int unsigned SPPR_DITHER2_BIT = 1;
  localparam int unsigned SPPR_DITHER1_BIT = 0;

  // amplitude register fields
  localparam int unsigned SPPR_AMP_B_LSB = 4;
  localparam int unsigned SPPR_AMP_A_LSB = 0;

  // aux power-down fields
  localparam int unsigned SPPR_SYNC_POWER_DOWN_BIT = 4;
  localparam int unsigned SPPR_PD_REF_DET_BIT = 2;
  localparam int unsigned SPPR_TEMP_ADC_POWER_DOWN_BIT = 1;

  // main power-down fields
  localparam int unsigned SPPR_PD_GLOBAL_BIT = 7;
  localparam int unsigned SPPR_PD_REF_DIV_BIT = 6;
  localparam int unsigned SPPR_PD_FB_DIV_BIT = 5;
  localparam int unsigned SPPR_PD_OSC_BIT = 4;
  localparam int unsigned SPPR_PD_LOCK_BIT = 3;
  localparam int unsigned SPPR_PD_PFD_BIT = 2;
  localparam int unsigned SPPR_PD_OUT_A_BIT = 1;
  localparam int unsigned SPPR_PD_OUT_B_BIT = 0;

  // lock detector fields
  localparam int unsigned SPPR_LOCK_WIN_LSB = 5;
  localparam int unsigned SPPR_LOCK_COUNT_LSB = 0;

  typedef enum logic [1:0] {
    SPPR_POL_NEVER = 2'b00,
    SPPR_POL_ALWAYS = 2'b01,
    SPPR_POL_DUTY_HIGH = 2'b10,
    SPPR_POL_DUTY_LOW = 2'b11
  } sppr_polarity_t;

  typedef enum logic [0:0] {
    SPPR_RS_IDLE = 1'b0,
    SPPR_RS_WAIT = 1'b1
  } sppr_resync_state_t;

  typedef struct packed {
    logic global_pd;
    logic ref_div_pd;
    logic fb_div_pd;
    logic osc_pd;
    logic lock_det_pd;
    logic pfd_pd;
    logic out_a_pd;
    logic out_b_pd;
    logic sync_pd;
    logic ref_det_pd;
    logic temp_adc_pd;
  } sppr_pd_t;

  typedef struct packed {
    logic retime_edge_select;
    sppr_polarity_t ref_polarity_select;
    logic [1:0] ref_clock_div_code;
    logic [1:0] fb_clock_div_code;
    logic resync_reset_source;
  } sppr_sync_t;

  typedef struct packed {
    logic lsb_plus_one_enable;
    logic aux_modulator_enable;
    logic [2:0] first_dither_lsb_position;
    logic second_accum_dither_enable;
    logic first_accum_dither_enable;
    logic [3:0] out_b_amplitude;
    logic [3:0] out_a_amplitude;
  } sppr_mod_t;

endpackage : sppr_pkg

/* File: design/sppr_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module sppr_regs
  import sppr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [SPPR_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // enables held in neighbouring registers
  input wire logic resync_mode_enable_in,
  input wire logic lock_window_enable_in,
  // resync timing
  input wire logic cal_sync_done_in,
  output logic resync_apply_out,
  // lock detection
  input wire logic pfd_tick_in,
  input wire logic phase_coincident_in,
  output logic lock_out,
  output logic [2:0] lock_window_width_out,
  // decoded configuration
  output logic [23:0] phase_word_out,
  output sppr_sync_t sync_cfg_out,
  output sppr_mod_t mod_cfg_out,
  output sppr_pd_t power_down_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register bank
  logic [7:0] ph_low_reg, ph_mid_reg, ph_high_reg, retime_reg, wait_low_reg;
  logic [7:0] wait_high_reg, rsvd_a_reg, mod_reg, amp_reg, aux_pd_reg;
  logic [7:0] main_pd_reg, lock_cfg_reg, rdata_reg;
  logic [7:0] ph_low_next, ph_mid_next, ph_high_next, retime_next, wait_low_next;
  logic [7:0] wait_high_next, rsvd_a_next, mod_next, amp_next, aux_pd_next;
  logic [7:0] main_pd_next, lock_cfg_next, rdata_next;

  always_comb begin
    ph_low_next = ph_low_reg;
    ph_mid_next = ph_mid_reg;
    ph_high_next = ph_high_reg;
    retime_next = retime_reg;
    wait_low_next = wait_low_reg;
    wait_high_next = wait_high_reg;
    rsvd_a_next = rsvd_a_reg;
    mod_next = mod_reg;
    amp_next = amp_reg;
    aux_pd_next = aux_pd_reg;
    main_pd_next = main_pd_reg;
    lock_cfg_next = lock_cfg_reg;
    rdata_next = rdata_reg;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        SPPR_PHASE_LOW_ADDR: ph_low_next = reg_wdata_in;
        SPPR_PHASE_MID_ADDR: ph_mid_next = reg_wdata_in;
        SPPR_PHASE_HIGH_ADDR: ph_high_next = reg_wdata_in;
        SPPR_RETIME_DIV_ADDR: retime_next = reg_wdata_in;
        SPPR_WAIT_LOW_ADDR: wait_low_next = reg_wdata_in;
        SPPR_WAIT_HIGH_ADDR: wait_high_next = reg_wdata_in;
        SPPR_RSVD_A_ADDR: rsvd_a_next = reg_wdata_in;
        SPPR_MOD_DITHER_ADDR: mod_next = reg_wdata_in;
        SPPR_AMPLITUDE_ADDR: amp_next = reg_wdata_in;
        SPPR_AUX_PD_ADDR: aux_pd_next = reg_wdata_in;
        SPPR_MAIN_PD_ADDR: main_pd_next = reg_wdata_in;
        SPPR_LOCK_CFG_ADDR: lock_cfg_next = reg_wdata_in;
        default: ;
      endcase
    end
    // readback, old value if written same cycle
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        SPPR_PHASE_LOW_ADDR: rdata_next = ph_low_reg;
        SPPR_PHASE_MID_ADDR: rdata_next = ph_mid_reg;
        SPPR_PHASE_HIGH_ADDR: rdata_next = ph_high_reg;
        SPPR_RETIME_DIV_ADDR: rdata_next = retime_reg;
        SPPR_WAIT_LOW_ADDR: rdata_next = wait_low_reg;
        SPPR_WAIT_HIGH_ADDR: rdata_next = wait_high_reg;
        SPPR_RSVD_A_ADDR: rdata_next = rsvd_a_reg;
        SPPR_MOD_DITHER_ADDR: rdata_next = mod_reg;
        SPPR_AMPLITUDE_ADDR: rdata_next = amp_reg;
        SPPR_AUX_PD_ADDR: rdata_next = aux_pd_reg;
        SPPR_MAIN_PD_ADDR: rdata_next = main_pd_reg;
        SPPR_LOCK_CFG_ADDR: rdata_next = lock_cfg_reg;
        default: rdata_next = SPPR_ZERO_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ph_low_reg <= SPPR_ZERO_RESET;
      ph_mid_reg <= SPPR_ZERO_RESET;
      ph_high_reg <= SPPR_ZERO_RESET;
      retime_reg <= SPPR_ZERO_RESET;
      wait_low_reg <= SPPR_ZERO_RESET;
      wait_high_reg <= SPPR_ZERO_RESET;
      rsvd_a_reg <= SPPR_ZERO_RESET;
      mod_reg <= SPPR_ZERO_RESET;
      amp_reg <= SPPR_ZERO_RESET;
      aux_pd_reg <= SPPR_AUX_PD_RESET;
      main_pd_reg <= SPPR_MAIN_PD_RESET;
      lock_cfg_reg <= SPPR_ZERO_RESET;
      rdata_reg <= SPPR_ZERO_RESET;
    end else begin
      ph_low_reg <= ph_low_next;
      ph_mid_reg <= ph_mid_next;
      ph_high_reg <= ph_high_next;
      retime_reg <= retime_next;
      wait_low_reg <= wait_low_next;
      wait_high_reg <= wait_high_next;
      rsvd_a_reg <= rsvd_a_next;
      mod_reg <= mod_next;
      amp_reg <= amp_next;
      aux_pd_reg <= aux_pd_next;
      main_pd_reg <= main_pd_next;
      lock_cfg_reg <= lock_cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decoded configuration, one flop behind the bank
  logic [23:0] phase_word_reg, phase_word_next;
  sppr_sync_t sync_reg, sync_next;
  sppr_mod_t mod_cfg_reg, mod_cfg_next;
  sppr_pd_t pd_reg, pd_next;
  logic [2:0] win_reg, win_next;

  always_comb begin
    phase_word_next = {ph_high_reg, ph_mid_reg, ph_low_reg};
    sync_next.retime_edge_select = retime_reg[SPPR_RETIME_EDGE_BIT];
    sync_next.ref_polarity_select = sppr_polarity_t'(retime_reg[SPPR_POLARITY_LSB +: 2]);
    sync_next.ref_clock_div_code = retime_reg[SPPR_SHARED_DIV_LSB +: 2];
    sync_next.fb_clock_div_code = retime_reg[SPPR_DIV_SOURCE_BIT] ?
        retime_reg[SPPR_FB_DIV_LSB +: 2] : retime_reg[SPPR_SHARED_DIV_LSB +: 2];
    sync_next.resync_reset_source = mod_reg[SPPR_RESYNC_SRC_BIT];
    mod_cfg_next.lsb_plus_one_enable = mod_reg[SPPR_LSB_PLUS_ONE_ENABLE_BIT];
    mod_cfg_next.aux_modulator_enable = mod_reg[SPPR_AUX_MOD_BIT];
    mod_cfg_next.first_dither_lsb_position = mod_reg[SPPR_DITHER_POS_LSB +: 3];
    mod_cfg_next.second_accum_dither_enable = mod_reg[SPPR_DITHER2_BIT];
    mod_cfg_next.first_accum_dither_enable = mod_reg[SPPR_DITHER1_BIT];
    mod_cfg_next.out_b_amplitude = amp_reg[SPPR_AMP_B_LSB +: 4];
    mod_cfg_next.out_a_amplitude = amp_reg[SPPR_AMP_A_LSB +: 4];
    pd_next.global_pd = main_pd_reg[SPPR_PD_GLOBAL_BIT];
    pd_next.ref_div_pd = main_pd_reg[SPPR_PD_REF_DIV_BIT];
    pd_next.fb_div_pd = main_pd_reg[SPPR_PD_FB_DIV_BIT];
    pd_next.osc_pd = main_pd_reg[SPPR_PD_OSC_BIT];
    pd_next.lock_det_pd = main_pd_reg[SPPR_PD_LOCK_BIT];
    pd_next.pfd_pd = main_pd_reg[SPPR_PD_PFD_BIT];
    pd_next.out_a_pd = main_pd_reg[SPPR_PD_OUT_A_BIT];
    pd_next.out_b_pd = main_pd_reg[SPPR_PD_OUT_B_BIT];
    pd_next.sync_pd = aux_pd_reg[SPPR_SYNC_POWER_DOWN_BIT];
    pd_next.ref_det_pd = aux_pd_reg[SPPR_PD_REF_DET_BIT];
    pd_next.temp_adc_pd = aux_pd_reg[SPPR_TEMP_ADC_POWER_DOWN_BIT];
    win_next = lock_window_enable_in ? lock_cfg_reg[SPPR_LOCK_WIN_LSB +: 3] : 3'h0;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase_word_reg <= '0;
      sync_reg <= '0;
      mod_cfg_reg <= '0;
      pd_reg <= '0;
      win_reg <= '0;
    end else begin
      phase_word_reg <= phase_word_next;
      sync_reg <= sync_next;
      mod_cfg_reg <= mod_cfg_next;
      pd_reg <= pd_next;
      win_reg <= win_next;
    end
  end

  assign phase_word_out = phase_word_reg;
  assign sync_cfg_out = sync_reg;
  assign mod_cfg_out = mod_cfg_reg;
  assign power_down_out = pd_reg;
  assign lock_window_width_out = win_reg;

  ////////////////////////////////////////////////////////////////////////////
  // resync wait timer
  sppr_resync_state_t rs_state_reg, rs_state_next;
  logic [15:0] rs_cnt_reg, rs_cnt_next;
  logic apply_reg, apply_next;

  always_comb begin
    rs_state_next = rs_state_reg;
    rs_cnt_next = rs_cnt_reg;
    apply_next = 1'b0;
    unique case (rs_state_reg)
      SPPR_RS_IDLE: begin
        if (cal_sync_done_in && resync_mode_enable_in) begin
          rs_state_next = SPPR_RS_WAIT;
          rs_cnt_next = {wait_high_reg, wait_low_reg};
        end
      end
      SPPR_RS_WAIT: begin
        if (rs_cnt_reg == 16'h0000) begin
          rs_state_next = SPPR_RS_IDLE;
          apply_next = 1'b1;
        end else begin
          rs_cnt_next = rs_cnt_reg - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rs_state_reg <= SPPR_RS_IDLE;
      rs_cnt_reg <= '0;
      apply_reg <= 1'b0;
    end else begin
      rs_state_reg <= rs_state_next;
      rs_cnt_reg <= rs_cnt_next;
      apply_reg <= apply_next;
    end
  end

  assign resync_apply_out = apply_reg;

  ////////////////////////////////////////////////////////////////////////////
  // lock qualification; held unlocked while detector or device is down
  logic [5:0] lk_cnt_reg, lk_cnt_next;
  logic lock_reg, lock_next;
  logic [5:0] lk_target;

  always_comb begin
    lk_target = {1'b0, lock_cfg_reg[SPPR_LOCK_COUNT_LSB +: 5]};
    lk_cnt_next = lk_cnt_reg;
    lock_next = lock_reg;
    if (main_pd_reg[SPPR_PD_LOCK_BIT] || main_pd_reg[SPPR_PD_GLOBAL_BIT]) begin
      lk_cnt_next = 6'h00;
      lock_next = 1'b0;
    end else if (pfd_tick_in) begin
      if (phase_coincident_in) begin
        if (lk_cnt_reg != 6'h20) begin
          lk_cnt_next = lk_cnt_reg + 6'h01;
        end
        lock_next = lock_reg || (lk_cnt_reg + 6'h01 >= lk_target);
      end else begin
        lk_cnt_next = 6'h00;
        lock_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lk_cnt_reg <= '0;
      lock_reg <= 1'b0;
    end else begin
      lk_cnt_reg <= lk_cnt_next;
      lock_reg <= lock_next;
    end
  end

  assign lock_out = lock_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_phase_high;
    @(posedge clk_in) disable iff (reset_in)
      reg_wr_in && reg_addr_in == SPPR_PHASE_HIGH_ADDR |=> ##1 phase_word_out[23:16] == $past(reg_wdata_in, 2);
  endproperty
  a_phase_high: assert property (p_phase_high) else $error("phase top byte wrong");

  property p_retime;
    @(posedge clk_in) disable iff (reset_in)
      ##1 sync_cfg_out.retime_edge_select == $past(retime_reg[SPPR_RETIME_EDGE_BIT]);
  endproperty
  a_retime: assert property (p_retime) else $error("retime edge mismatch");

  property p_fb_div;
    @(posedge clk_in) disable iff (reset_in)
      $past(retime_reg[SPPR_DIV_SOURCE_BIT]) |-> sync_cfg_out.fb_clock_div_code == $past(retime_reg[3:2]);
  endproperty
  a_fb_div: assert property (p_fb_div) else $error("dedicated divider not used");

  property p_shared_div;
    @(posedge clk_in) disable iff (reset_in)
      !$past(retime_reg[SPPR_DIV_SOURCE_BIT]) |-> sync_cfg_out.fb_clock_div_code == sync_cfg_out.ref_clock_div_code;
  endproperty
  a_shared_div: assert property (p_shared_div) else $error("shared divider not used");

  property p_resync_apply;
    @(posedge clk_in) disable iff (reset_in)
      rs_state_reg == SPPR_RS_IDLE && cal_sync_done_in && resync_mode_enable_in && wait_low_reg == 8'h02 &&
      wait_high_reg == 8'h00 && !reg_wr_in |=> !resync_apply_out [*3] ##1 resync_apply_out;
  endproperty
  a_resync_apply: assert property (p_resync_apply) else $error("resync wait wrong");

  property p_resync_gate;
    @(posedge clk_in) disable iff (reset_in)
      rs_state_reg == SPPR_RS_IDLE && !resync_mode_enable_in |=> rs_state_reg == SPPR_RS_IDLE;
  endproperty
  a_resync_gate: assert property (p_resync_gate) else $error("resync ran while disabled");

  property p_pd_reset;
    @(posedge clk_in) $fell(reset_in) |-> aux_pd_reg == SPPR_AUX_PD_RESET && main_pd_reg == SPPR_MAIN_PD_RESET;
  endproperty
  a_pd_reset: assert property (p_pd_reset) else $error("power-down reset value wrong");

  property p_lock;
    @(posedge clk_in) disable iff (reset_in)
      $rose(lock_out) |-> $past(pfd_tick_in && phase_coincident_in) && $past(lk_cnt_reg) + 6'h01 >= $past(lk_target);
  endproperty
  a_lock: assert property (p_lock) else $error("lock rose early");

  property p_window;
    @(posedge clk_in) disable iff (reset_in)
      !lock_window_enable_in |=> lock_window_width_out == 3'h0;
  endproperty
  a_window: assert property (p_window) else $error("window width while disabled");

  property p_readback;
    @(posedge clk_in) disable iff (reset_in)
      reg_wr_in && reg_addr_in == SPPR_AMPLITUDE_ADDR ##1 reg_rd_in && reg_addr_in == SPPR_AMPLITUDE_ADDR && !reg_wr_in
      |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

endmodule : sppr_regs
`default_nettype wire

/* File: tb/sppr_regs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sppr_regs_tb_top
  import sppr_pkg::*;
;
  logic clk_in;
  logic reset_in;
  logic [SPPR_ADDR_W-1:0] reg_addr_in;
  logic reg_wr_in;
  logic [7:0] reg_wdata_in;
  logic reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic resync_mode_enable_in;
  logic lock_window_enable_in;
  logic cal_sync_done_in;
  logic resync_apply_out;
  logic pfd_tick_in;
  logic phase_coincident_in;
  logic lock_out;
  logic [2:0] lock_window_width_out;
  logic [23:0] phase_word_out;
  sppr_sync_t sync_cfg_out;
  sppr_mod_t mod_cfg_out;
  sppr_pd_t power_down_out;
  int error_cnt;
  int checks;
  int cycles;
  logic [7:0] pat [12];

  sppr_regs sppr_regs_i (
    .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .resync_mode_enable_in(resync_mode_enable_in), .lock_window_enable_in(lock_window_enable_in),
    .cal_sync_done_in(cal_sync_done_in), .resync_apply_out(resync_apply_out),
    .pfd_tick_in(pfd_tick_in), .phase_coincident_in(phase_coincident_in), .lock_out(lock_out),
    .lock_window_width_out(lock_window_width_out), .phase_word_out(phase_word_out),
    .sync_cfg_out(sync_cfg_out), .mod_cfg_out(mod_cfg_out), .power_down_out(power_down_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // generous ceiling: the whole run needs a few hundred cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      $display("Error at %0t: run did not finish in time", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d, error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk("read data", 32'(reg_rdata_out), 32'(exp));
  endtask : rd_chk

  // decoded outputs lag a write by two edges
  task automatic settle();
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    logic [7:0] exp;
    settle();
    chk("pd decode", 32'(power_down_out), 32'({SPPR_MAIN_PD_RESET, 3'b010}));
    for (int i = 0; i < 12; i++) begin
      exp = (i == 9) ? SPPR_AUX_PD_RESET : (i == 10) ? SPPR_MAIN_PD_RESET : SPPR_ZERO_RESET;
      rd_chk(15'h0021 + 15'(i), exp);
    end
  endtask : t_reset_values

  task automatic t_readback();
    // reserved byte keeps its reset setting
    pat = '{8'h12, 8'h34, 8'h56, 8'hb6, 8'h03, 8'h00, 8'h00, 8'hd5, 8'h7e, 8'h16, 8'h54, 8'ha3};
    for (int i = 0; i < 12; i++) wr(15'h0021 + 15'(i), pat[i]);
    // unmapped places must neither store nor answer
    wr(15'h0030, 8'hff);
    rd_chk(15'h0030, 8'h00);
    rd_chk(15'h0020, 8'h00);
    for (int i = 0; i < 12; i++) rd_chk(15'h0021 + 15'(i), pat[i]);
    settle();
    chk("phase word", 32'(phase_word_out), 32'({pat[2], pat[1], pat[0]}));
    chk("mod cfg", 32'(mod_cfg_out), 32'({pat[7][6:0], pat[8]}));
    chk("pd decode", 32'(power_down_out), 32'({pat[10], pat[9][4], pat[9][2], pat[9][1]}));
    chk("resync src", 32'(sync_cfg_out.resync_reset_source), 32'(pat[7][7]));
    wr_rd(SPPR_AMPLITUDE_ADDR, 8'h9c);
    settle();
    chk("amp cfg", 32'({mod_cfg_out.out_b_amplitude, mod_cfg_out.out_a_amplitude}), 32'h0000_009c);
  endtask : t_readback

  // write, then read the same byte on the very next edge
  task automatic wr_rd(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk("read after write", 32'(reg_rdata_out), 32'(d));
  endtask : wr_rd

  // every polarity code, every divider code, both edge and source selects
  task automatic t_sync_fields();
    logic [7:0] v;
    logic [1:0] sh;
    logic [1:0] fb;
    for (int j = 0; j < 4; j++) begin
      sh = 2'(3 - j);
      fb = 2'(j);
      v = {j[0], 2'(j), j[0], fb, sh};
      wr(SPPR_RETIME_DIV_ADDR, v);
      settle();
      chk("sync cfg", 32'(sync_cfg_out), 32'({v[7:5], sh, j[0] ? fb : sh, pat[7][7]}));
    end
  endtask : t_sync_fields

  ////////////////////////////////////////////////////////////////////////////
  task automatic trigger(input logic en);
    @(posedge clk_in);
    resync_mode_enable_in <= en;
    cal_sync_done_in <= 1'b1;
    @(posedge clk_in);
    cal_sync_done_in <= 1'b0;
  endtask : trigger

  task automatic t_resync(input logic [15:0] w);
    int first;
    wr(SPPR_WAIT_LOW_ADDR, w[7:0]);
    wr(SPPR_WAIT_HIGH_ADDR, w[15:8]);
    trigger(1'b0);
    first = 0;
    for (int k = 1; k < 12; k++) begin
      @(posedge clk_in);
      #1;
      if (resync_apply_out === 1'b1) first = k;
    end
    chk("apply while disabled", 32'(first), 32'd0);
    trigger(1'b1);
    first = 0;
    for (int k = 1; k < 24; k++) begin
      @(posedge clk_in);
      #1;
      if (resync_apply_out === 1'b1 && first == 0) first = k;
      if (first != 0 && k == first + 1) chk("apply width", 32'(resync_apply_out), 32'd0);
    end
    // seen just after the edge that raises it, one before it is sampled
    chk("apply delay", 32'(first), 32'(w) + 32'd1);
  endtask : t_resync

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input logic c);
    @(posedge clk_in);
    pfd_tick_in <= 1'b1;
    phase_coincident_in <= c;
    @(posedge clk_in);
    pfd_tick_in <= 1'b0;
  endtask : tick

  task automatic t_lock();
    // count 3 in the low field, window width 5 above it
    wr(SPPR_LOCK_CFG_ADDR, 8'ha3);
    wr(SPPR_MAIN_PD_ADDR, 8'h00);
    settle();
    chk("window off", 32'(lock_window_width_out), 32'd0);
    @(posedge clk_in);
    lock_window_enable_in <= 1'b1;
    settle();
    chk("window on", 32'(lock_window_width_out), 32'd5);
    tick(1'b1);
    tick(1'b1);
    settle();
    chk("lock early", 32'(lock_out), 32'd0);
    tick(1'b1);
    settle();
    chk("lock reached", 32'(lock_out), 32'd1);
    tick(1'b0);
    settle();
    chk("lock lost", 32'(lock_out), 32'd0);
    repeat (3) tick(1'b1);
    settle();
    chk("lock again", 32'(lock_out), 32'd1);
    wr(SPPR_MAIN_PD_ADDR, 8'h08);
    settle();
    chk("lock powered down", 32'(lock_out), 32'd0);
    wr(SPPR_MAIN_PD_ADDR, 8'h00);
    repeat (3) tick(1'b1);
    settle();
    chk("lock after power-up", 32'(lock_out), 32'd1);
    wr(SPPR_MAIN_PD_ADDR, 8'h80);
    settle();
    chk("lock global down", 32'(lock_out), 32'd0);
    tick(1'b1);
    settle();
    chk("tick ignored while down", 32'(lock_out), 32'd0);
  endtask : t_lock

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_in = 1'b1;
    reg_addr_in = '0;
    reg_wr_in = 1'b0;
    reg_wdata_in = 8'h00;
    reg_rd_in = 1'b0;
    resync_mode_enable_in = 1'b0;
    lock_window_enable_in = 1'b0;
    cal_sync_done_in = 1'b0;
    pfd_tick_in = 1'b0;
    phase_coincident_in = 1'b0;
    error_cnt = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset_values();
    t_readback();
    t_sync_fields();
    t_resync(16'h0003);
    t_resync(16'h0000);
    t_resync(16'h0002);
    t_lock();
    conclude();
  end
endmodule : sppr_regs_tb_top
`default_nettype wire
